/* File: design/flow_pkg.sv */
/*
 * constants for the program-flow, return-stack, indirect access and
 * irq enable block: register indices, field positions, reset values.
 * assumes a word-wide wishbone slave where the byte address is four
 * times the register index.
 */
package flow_pkg;
   // register indices; byte address is index * 4
   localparam logic [8:0] IDX_WINDOW = 9'h000;
   localparam logic [8:0] IDX_LOW_BYTE = 9'h002;
   localparam logic [8:0] IDX_POINTER = 9'h004;
   localparam logic [8:0] IDX_HOLDING = 9'h00a;
   localparam logic [8:0] IDX_IRQCTL = 9'h00b;
   localparam logic [8:0] IDX_IRQCTL_ALIAS = 9'h08b;
   localparam logic [4:0] IDX_RAM_PAGE = 5'h02;
   localparam logic [8:0] IDX_EVT_STATUS = 9'h040;
   localparam logic [8:0] IDX_EVT_MASK = 9'h041;
   localparam int RAM_WORDS = 16;

   // irq_enable_ctl fields
   localparam int GLOBAL_EN_BIT = 7;
   localparam int EEPROM_EN_BIT = 6;
   localparam int TIMER_EN_BIT = 5;
   localparam int PIN_EN_BIT = 4;
   localparam int PORT_EN_BIT = 3;
   localparam int TIMER_FLAG_BIT = 2;
   localparam int PIN_FLAG_BIT = 1;
   localparam int PORT_FLAG_BIT = 0;
   localparam logic [7:0] IRQCTL_RST = 8'h00;

   // program flow
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam logic [4:0] HOLDING_RST = 5'h00;
   localparam logic [7:0] POINTER_RST = 8'h00;

   // event status / mask fields
   localparam int EVT_W = 4;
   localparam int EVT_PUSH = 0;
   localparam int EVT_POP = 1;
   localparam int EVT_WRAP = 2;
   localparam int EVT_IRQ = 3;
   localparam logic [3:0] EVT_MASK_RST = 4'h0;
endpackage

/* File: design/program_flow_irq_enable.sv */
/*
 * program counter, 8-level circular return stack, indirect register
 * window and irq enable/flag register of a small 8-bit core, with a
 * classic wishbone slave and an event interrupt output.
 * assumes the core pulses the flow inputs for one cycle each and that
 * the timer, pin and port-change sources give one-cycle event pulses.
 */
module program_flow_irq_enable
   import flow_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // core flow strobes
   input wire logic pc_step_i,
   input wire logic call_i,
   input wire logic [10:0] call_target_i,
   input wire logic return_i,
   input wire logic irq_exit_i,
   input wire logic irq_branch_i,
   // interrupt source events
   input wire logic timer_overflow_evt_i,
   input wire logic ext_pin_evt_i,
   input wire logic port_change_evt_i,
   // outputs
   output logic [12:0] program_counter_o,
   output logic irq_request_o,
   output logic irq_o
);

   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [4:0] holding;
      logic [7:0] irqctl;
      logic [7:0] pointer;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
      logic [2:0] sp;
      logic [3:0] depth;
      logic [RAM_WORDS-1:0][7:0] ram;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic ack;
      logic [7:0] dat;
      logic irq_req;
      logic irq;
   } state_s;

   state_s q_r;
   state_s q_nxt;

   logic [8:0] idx;
   logic [8:0] tgt;
   logic self_ref;
   logic acc;
   logic wr;
   logic rd;
   logic push;
   logic pop;
   logic [EVT_W-1:0] evt_set;
   logic [PC_W-1:0] top_entry;

   // window redirects through pointer; bank bit is ignored
   always_comb begin
      idx = wb_adr_i[10:2];
      self_ref = 1'b0;
      tgt = idx;
      if (idx == IDX_WINDOW) begin
         tgt = {1'b0, q_r.pointer};
         self_ref = (q_r.pointer == 8'h00);
      end
   end

   assign acc = wb_cyc_i && wb_stb_i && !q_r.ack && !wb_adr_i[11];
   // a write lands at the edge where the master sees ack, so that the
   // register and the bus cycle never disagree about when it happened
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
      q_r.ack && !wb_adr_i[11];
   assign rd = acc && !wb_we_i;
   // interrupt branch wins over call; a return in the same cycle loses
   assign push = irq_branch_i || call_i;
   assign pop = !push && (return_i || irq_exit_i);
   assign top_entry = q_r.stack[q_r.sp - 3'd1];

   function automatic logic [7:0] read_reg(input state_s s,
                                           input logic [8:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a[8:4] == IDX_RAM_PAGE) begin
         v = s.ram[a[3:0]];
      end else begin
         unique case (a)
            IDX_LOW_BYTE: v = s.pc[7:0];
            IDX_POINTER: v = s.pointer;
            IDX_HOLDING: v = {3'h0, s.holding};
            IDX_IRQCTL, IDX_IRQCTL_ALIAS: v = s.irqctl;
            IDX_EVT_STATUS: v = {4'h0, s.evt};
            IDX_EVT_MASK: v = {4'h0, s.mask};
            default: v = 8'h00;
         endcase
      end
      return v;
   endfunction

   always_comb begin
      q_nxt = q_r;
      evt_set = '0;
      q_nxt.ack = wb_cyc_i && wb_stb_i && !q_r.ack;
      q_nxt.dat = 8'h00;
      if (rd && !self_ref) begin
         q_nxt.dat = read_reg(q_r, tgt);
      end
      // register writes; a write through the window to itself is dropped
      if (wr && !self_ref) begin
         if (tgt[8:4] == IDX_RAM_PAGE) begin
            q_nxt.ram[tgt[3:0]] = wb_dat_i[7:0];
         end else begin
            unique case (tgt)
               IDX_POINTER: q_nxt.pointer = wb_dat_i[7:0];
               IDX_HOLDING: q_nxt.holding = wb_dat_i[4:0];
               // flags are cleared only by this write
               IDX_IRQCTL, IDX_IRQCTL_ALIAS: begin
                  q_nxt.irqctl = wb_dat_i[7:0];
               end
               IDX_EVT_MASK: q_nxt.mask = wb_dat_i[EVT_W-1:0];
               default: q_nxt.pointer = q_nxt.pointer;
            endcase
         end
      end
      // read of the event status clears it
      if (rd && !self_ref && tgt == IDX_EVT_STATUS) begin
         q_nxt.evt = '0;
      end
      // program counter; a low-byte write takes bits 12:8 from holding, a call only bits 12:11
      if (irq_branch_i) begin
         q_nxt.pc = IRQ_VECTOR;
      end else if (call_i) begin
         q_nxt.pc = {q_r.holding[4:3], call_target_i};
      end else if (pop) begin
         q_nxt.pc = q_r.stack[q_r.sp - 3'd1];
      end else if (wr && !self_ref && tgt == IDX_LOW_BYTE) begin
         q_nxt.pc = {q_r.holding, wb_dat_i[7:0]};
      end else if (pc_step_i) begin
         q_nxt.pc = q_r.pc + 13'd1;
      end
      // stack; holding is not touched here
      if (push) begin
         q_nxt.stack[q_r.sp] = q_r.pc;
         q_nxt.sp = q_r.sp + 3'd1;
         evt_set[EVT_PUSH] = 1'b1;
         if (q_r.depth == 4'(STACK_DEPTH)) begin
            evt_set[EVT_WRAP] = 1'b1;
         end else begin
            q_nxt.depth = q_r.depth + 4'd1;
         end
      end else if (pop) begin
         q_nxt.sp = q_r.sp - 3'd1;
         evt_set[EVT_POP] = 1'b1;
         if (q_r.depth != 4'd0) begin
            q_nxt.depth = q_r.depth - 4'd1;
         end
      end
      // the branch masks further interrupts until the exit restores it
      if (irq_branch_i) begin
         q_nxt.irqctl[GLOBAL_EN_BIT] = 1'b0;
         evt_set[EVT_IRQ] = 1'b1;
      end else if (irq_exit_i && pop) begin
         q_nxt.irqctl[GLOBAL_EN_BIT] = 1'b1;
      end
      // hardware set wins over a software clear in the same cycle
      if (timer_overflow_evt_i) begin
         q_nxt.irqctl[TIMER_FLAG_BIT] = 1'b1;
      end
      if (ext_pin_evt_i) begin
         q_nxt.irqctl[PIN_FLAG_BIT] = 1'b1;
      end
      if (port_change_evt_i) begin
         q_nxt.irqctl[PORT_FLAG_BIT] = 1'b1;
      end
      q_nxt.evt = q_nxt.evt | evt_set;
      // registered request: one cycle behind the bits it is built from
      q_nxt.irq_req = q_r.irqctl[GLOBAL_EN_BIT] &&
         ((q_r.irqctl[TIMER_EN_BIT] && q_r.irqctl[TIMER_FLAG_BIT]) ||
          (q_r.irqctl[PIN_EN_BIT] && q_r.irqctl[PIN_FLAG_BIT]) ||
          (q_r.irqctl[PORT_EN_BIT] && q_r.irqctl[PORT_FLAG_BIT]));
      q_nxt.irq = |(q_nxt.evt & q_r.mask);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q_r.pc <= PC_RST;
         q_r.holding <= HOLDING_RST;
         q_r.irqctl <= IRQCTL_RST;
         q_r.pointer <= POINTER_RST;
         q_r.stack <= '0;
         q_r.sp <= 3'h0;
         q_r.depth <= 4'h0;
         q_r.ram <= '0;
         q_r.evt <= '0;
         q_r.mask <= EVT_MASK_RST;
         q_r.ack <= 1'b0;
         q_r.dat <= 8'h00;
         q_r.irq_req <= 1'b0;
         q_r.irq <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign wb_ack_o = q_r.ack;
   assign wb_dat_o = {24'h000000, q_r.dat};
   assign program_counter_o = q_r.pc;
   assign irq_request_o = q_r.irq_req;
   assign irq_o = q_r.irq;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   alias_write_a: assert property (
      wr && !self_ref && tgt == IDX_IRQCTL_ALIAS && !irq_branch_i &&
      !irq_exit_i |=> q_r.irqctl[7:3] == $past(wb_dat_i[7:3]))
      else $error("alias write did not reach irq control");

   flag_set_a: assert property (
      timer_overflow_evt_i |=> q_r.irqctl[TIMER_FLAG_BIT])
      else $error("timer flag not set by its event");

   pin_flag_a: assert property (
      ext_pin_evt_i |=> q_r.irqctl[PIN_FLAG_BIT])
      else $error("pin flag not set by its event");

   port_flag_a: assert property (
      port_change_evt_i |=> q_r.irqctl[PORT_FLAG_BIT])
      else $error("port change flag not set by its event");

   flag_kept_a: assert property (
      q_r.irqctl[TIMER_FLAG_BIT] && !wr |=> q_r.irqctl[TIMER_FLAG_BIT])
      else $error("timer flag cleared without a write");

   global_gate_a: assert property (
      !q_r.irqctl[GLOBAL_EN_BIT] |=> !irq_request_o)
      else $error("request raised with global enable off");

   request_cause_a: assert property (
      q_r.irqctl[GLOBAL_EN_BIT] && q_r.irqctl[PIN_EN_BIT] &&
      q_r.irqctl[PIN_FLAG_BIT] |=> irq_request_o)
      else $error("enabled pending source gave no request");

   pcl_read_a: assert property (
      rd && idx == IDX_LOW_BYTE |=> wb_ack_o &&
      wb_dat_o[7:0] == $past(q_r.pc[7:0]))
      else $error("low counter byte read wrong");

   branch_vector_a: assert property (
      irq_branch_i |=> program_counter_o == IRQ_VECTOR &&
      !q_r.irqctl[GLOBAL_EN_BIT])
      else $error("interrupt branch did not reach the vector");

   pop_load_a: assert property (
      pop |=> program_counter_o == $past(top_entry))
      else $error("return did not load the top stack entry");

   step_a: assert property (
      pc_step_i && !push && !pop && !wr
      |=> program_counter_o == $past(program_counter_o) + 13'd1)
      else $error("counter step did not add one");

   window_read_a: assert property (
      rd && idx == IDX_WINDOW && q_r.pointer == IDX_POINTER[7:0]
      |=> wb_dat_o[7:0] == $past(q_r.pointer))
      else $error("window read did not follow the pointer");

   pointer_only_a: assert property (
      acc && idx == IDX_WINDOW |-> tgt[8] == 1'b0)
      else $error("window target used a bank bit");

   unmapped_read_a: assert property (
      wb_cyc_i && wb_stb_i && !q_r.ack && !wb_we_i && wb_adr_i[11]
      |=> wb_ack_o && wb_dat_o == 32'h00000000)
      else $error("unmapped read not answered with zero");

   high_from_holding_a: assert property (
      wr && tgt == IDX_LOW_BYTE && !self_ref && !push && !pop
      |=> q_r.pc[12:8] == $past(q_r.holding))
      else $error("counter high part not from holding");

   push_pop_pair_a: assert property (
      call_i && !irq_branch_i ##1 return_i && !call_i && !irq_branch_i
      |=> q_r.pc == $past(q_r.pc, 2))
      else $error("return did not restore pushed counter");

   holding_kept_a: assert property (
      (push || pop) && !wr |=> $stable(q_r.holding))
      else $error("stack operation changed holding");

   circular_wrap_a: assert property (
      push |=> q_r.sp == $past(q_r.sp) + 3'd1)
      else $error("stack pointer did not advance modulo eight");

   self_read_a: assert property (
      rd && self_ref |=> wb_dat_o == 32'h00000000)
      else $error("window read through itself not zero");

   self_write_a: assert property (
      wr && self_ref |=> $stable(q_r.ram) && $stable(q_r.pointer) &&
      $stable(q_r.holding) && $stable(q_r.mask))
      else $error("window write through itself changed state");

   ack_one_a: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   call_cover_c: cover property (call_i ##1 return_i);
   wrap_cover_c: cover property (push && q_r.depth == 4'(STACK_DEPTH));
   irq_cover_c: cover property (irq_request_o ##1 irq_branch_i);
   window_cover_c: cover property (rd && idx == IDX_WINDOW && !self_ref);
   underflow_cover_c: cover property (pop && q_r.depth == 4'd0);

endmodule

/* File: test/program_flow_irq_enable_tb.sv */
/*
 * self-checking bench for program_flow_irq_enable: wishbone register
 * access, interrupt flags, program counter, return stack and window.
 * assumes the flow_pkg register indices and a single 100 MHz clock.
 */
module program_flow_irq_enable_tb import flow_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq_req, irq;
   logic [11:0] wb_adr;
   logic [31:0] wb_dat_w, wb_dat_r;
   logic [4:0] fl;
   logic [2:0] ev;
   logic [10:0] tgt;
   logic [12:0] pc;
   logic [7:0] q;
   int error_cnt = 0;
   int n_checks = 0;
   program_flow_irq_enable i_program_flow_irq_enable (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
      .pc_step_i(fl[0]), .call_i(fl[1]), .call_target_i(tgt),
      .return_i(fl[2]), .irq_exit_i(fl[3]), .irq_branch_i(fl[4]),
      .timer_overflow_evt_i(ev[2]), .ext_pin_evt_i(ev[1]),
      .port_change_evt_i(ev[0]), .program_counter_o(pc),
      .irq_request_o(irq_req), .irq_o(irq));
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // the answer comes one cycle after the request; the wait is still bounded at 20 cycles
   task wb(input logic we, input logic [11:0] a, input logic [7:0] d);
      int i;
      @(posedge clk_sys_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_w <= {24'h0, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys_i);
         if (wb_ack === 1'b1) break;
      end
      if (i == 20) begin
         error_cnt++;
         summarize();
      end
      q = wb_dat_r[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      // a write lands at the ack edge; let it settle before any check
      #1;
   endtask
   task wr(input logic [8:0] x, input logic [7:0] d);
      wb(1'b1, {1'b0, x, 2'b00}, d);
   endtask
   task rd(input logic [8:0] x);
      wb(1'b0, {1'b0, x, 2'b00}, 8'h00);
   endtask
   task pulse(input logic [4:0] f, input logic [2:0] e, input logic [10:0] t);
      @(posedge clk_sys_i);
      fl <= f;
      ev <= e;
      tgt <= t;
      @(posedge clk_sys_i);
      fl <= 5'h00;
      ev <= 3'h0;
      #1;
   endtask
   task settle;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask
   task t_reset;
      check("pc", {19'h0, pc}, 32'h0);
      rd(IDX_IRQCTL);
      check("ctl", {24'h0, q}, 32'h0);
      wb(1'b0, 12'h800, 8'h00); check("unmapped", {24'h0, q}, 32'h0);
   endtask
   task t_alias;
      wr(IDX_IRQCTL, 8'h78);
      rd(IDX_IRQCTL_ALIAS);
      check("alias", {24'h0, q}, 32'h78);
      wr(IDX_IRQCTL_ALIAS, 8'h40);
      rd(IDX_IRQCTL);
      check("ctl", {24'h0, q}, 32'h40);
      wr(IDX_IRQCTL, 8'h00);
   endtask
   task t_flags;
      pulse(5'h00, 3'h7, 11'h0);
      rd(IDX_IRQCTL);
      check("flags", {24'h0, q}, 32'h07);
      wr(IDX_IRQCTL, 8'h3f); settle();
      check("req gie off", {31'h0, irq_req}, 32'h0);
      wr(IDX_IRQCTL, 8'hbf); settle();
      check("req on", {31'h0, irq_req}, 32'h1);
      wr(IDX_IRQCTL, 8'hb8); settle();
      check("req cleared", {31'h0, irq_req}, 32'h0);
      wr(IDX_IRQCTL, 8'h80);
      pulse(5'h00, 3'h7, 11'h0); settle();
      check("req no en", {31'h0, irq_req}, 32'h0);
      wr(IDX_IRQCTL, 8'h00);
   endtask
   task t_pc;
      wr(IDX_LOW_BYTE, 8'h55);
      check("pcl wr", {19'h0, pc}, 32'h55);
      wr(IDX_HOLDING, 8'h1f);
      check("pc hold", {19'h0, pc}, 32'h55);
      pulse(5'h02, 3'h0, 11'h123);
      check("pc call", {19'h0, pc}, 32'h1923);
      rd(IDX_LOW_BYTE);
      check("pcl rd", {24'h0, q}, 32'h23);
      pulse(5'h04, 3'h0, 11'h0);
      check("pc ret", {19'h0, pc}, 32'h55);
      rd(IDX_HOLDING);
      check("holding", {24'h0, q}, 32'h1f);
      pulse(5'h01, 3'h0, 11'h0);
      check("pc step", {19'h0, pc}, 32'h56);
   endtask
   task t_stack;
      wr(IDX_HOLDING, 8'h00);
      wr(IDX_EVT_MASK, 8'h00);
      rd(IDX_EVT_STATUS);
      for (int k = 1; k <= 9; k++) pulse(5'h02, 3'h0, 11'h100 + 11'(k));
      settle(); check("irq masked", {31'h0, irq}, 32'h0);
      wr(IDX_EVT_MASK, 8'h04); settle();
      check("irq set", {31'h0, irq}, 32'h1);
      rd(IDX_EVT_STATUS);
      check("status", {24'h0, q}, 32'h05);
      settle(); check("irq clr", {31'h0, irq}, 32'h0);
      for (int k = 1; k <= 8; k++) begin
         pulse(5'h04, 3'h0, 11'h0);
         check("pop", {19'h0, pc}, 32'h100 + 32'(9 - k));
      end
      // the ninth push landed on the first slot, so it comes back again
      pulse(5'h04, 3'h0, 11'h0);
      check("wrap", {19'h0, pc}, 32'h108);
      wr(IDX_IRQCTL, 8'h80);
      pulse(5'h10, 3'h0, 11'h0);
      check("vector", {19'h0, pc}, 32'h4);
      pulse(5'h08, 3'h0, 11'h0);
      check("irq ret", {19'h0, pc}, 32'h108);
      rd(IDX_IRQCTL); check("gie", {24'h0, q}, 32'h80);
   endtask
   task t_window;
      wr(IDX_POINTER, 8'h21);
      wr(IDX_WINDOW, 8'ha5);
      rd(9'h021);
      check("win wr", {24'h0, q}, 32'ha5);
      wr(9'h022, 8'h3c);
      wr(IDX_POINTER, 8'h22);
      rd(IDX_WINDOW);
      check("win rd", {24'h0, q}, 32'h3c);
      wr(IDX_POINTER, 8'h8b);
      wr(IDX_WINDOW, 8'h48);
      rd(IDX_IRQCTL);
      check("win alias", {24'h0, q}, 32'h48);
      wr(IDX_POINTER, 8'h00);
      rd(IDX_WINDOW);
      check("win self", {24'h0, q}, 32'h0);
      wr(IDX_WINDOW, 8'h77);
      rd(IDX_POINTER);
      check("ptr kept", {24'h0, q}, 32'h0);
      rd(9'h021);
      check("ram kept", {24'h0, q}, 32'ha5);
      wr(IDX_IRQCTL, 8'h00);
   endtask
   initial begin
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we} = 3'h0;
      wb_adr = 12'h000;
      wb_dat_w = 32'h0;
      fl = 5'h00;
      ev = 3'h0;
      tgt = 11'h000;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset();
      t_alias();
      t_flags();
      t_pc();
      t_stack();
      t_window();
      summarize();
   end
endmodule
